// *** auto_zero_scheduler_bench.sv ***
module auto_zero_scheduler_bench
    import azs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] S_V = 24'h001200;
    localparam logic [23:0] R_V = 24'h008000;
    localparam logic [23:0] Z_V = 24'h000100;
    logic ref_clk, rst, wr, rd, slow, conv_start, conv_done, reading_valid, engine_idle;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] conv_phase;
    logic [23:0] conv_data, reading_result, reading_span;
    int compares = 0;
    int miscompares = 0;
    int zc = 0;
    int z0;
    azs_scheduler #(.ZERO_PERIOD_CYC(24'd400)) dut (.ref_clk(ref_clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .conv_start(conv_start), .conv_phase(conv_phase), .conv_done(conv_done),
        .conv_data(conv_data), .reading_valid(reading_valid),
        .reading_result(reading_result), .reading_span(reading_span),
        .engine_idle(engine_idle));
    azs_conv_model #(.S_VAL(S_V), .R_VAL(R_V), .Z_VAL(Z_V)) conv (.ref_clk(ref_clk),
        .rst(rst), .conv_start(conv_start), .conv_phase(conv_phase), .slow(slow),
        .conv_done(conv_done), .conv_data(conv_data));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (conv_start === 1'b1 && conv_phase === AZS_PH_ZERO)
            zc++;
    end
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        cmp(v, exp);
    endtask
    // bounded wait for reading_valid (0) or engine_idle (1)
    task automatic wait_hi(input bit idle_flag);
        repeat (400) begin
            @(posedge ref_clk);
            #1;
            if ((idle_flag ? engine_idle : reading_valid) === 1'b1)
                return;
        end
        cmp(32'h0, 32'h1);
    endtask
    // one initiated reading: results and the number of zero phases it used
    task automatic conv_once(input int zeros);
        z0 = zc;
        wr_reg(AZS_CMD_ADDR, 32'h2);
        wait_hi(1'b0);
        cmp(32'(reading_result), 32'(S_V - Z_V));
        cmp(32'(reading_span), 32'(R_V - Z_V));
        cmp(32'(zc - z0), 32'(zeros));
        wait_hi(1'b1);
    endtask
    initial begin
        rst = 1'b1;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        slow = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk(AZS_CTRL_ADDR, 32'h1);
        chk(AZS_STATUS_ADDR, 32'h9);
        chk(AZS_TYPE_QUERY_ADDR, AZS_ANS_PERIODIC);
        chk(AZS_ENABLE_QUERY_ADDR, 32'(AZS_ANS_ON));
        chk(8'h14, 32'h0);
        chk(AZS_CMD_ADDR, 32'h0);
        $display("test defaults done");
        conv_once(1);
        conv_once(0);
        $display("test periodic single done");
        z0 = zc;
        slow <= 1'b1;
        wr_reg(AZS_CTRL_ADDR, 32'h5);
        repeat (1000) @(posedge ref_clk);
        cmp(32'((zc - z0) inside {[2:3]}), 32'h1);
        $display("test periodic refresh done");
        wr_reg(AZS_CTRL_ADDR, 32'h4);
        chk(AZS_ENABLE_QUERY_ADDR, 32'(AZS_ANS_ON));
        chk(AZS_CTRL_ADDR, 32'h5);
        wr_reg(AZS_CTRL_ADDR, 32'h1);
        wr_reg(AZS_CMD_ADDR, 32'h1);
        @(posedge ref_clk);
        #1 cmp(32'(engine_idle), 32'h1);
        // the job cut off by the abort must run out before the next start
        repeat (14) @(posedge ref_clk);
        #1 cmp(32'(engine_idle), 32'h1);
        rd_reg(AZS_STATUS_ADDR);
        cmp(v & 32'h7, 32'h5);
        wr_reg(AZS_CMD_ADDR, 32'h8);
        rd_reg(AZS_STATUS_ADDR);
        cmp(v & 32'h7, 32'h1);
        $display("test refuse and abort done");
        slow <= 1'b0;
        wr_reg(AZS_CTRL_ADDR, 32'h0);
        chk(AZS_ENABLE_QUERY_ADDR, 32'(AZS_ANS_OFF));
        conv_once(0);
        wr_reg(AZS_CTRL_ADDR, 32'h3);
        chk(AZS_TYPE_QUERY_ADDR, AZS_ANS_EVERY_READING);
        conv_once(1);
        conv_once(1);
        $display("test disable and every reading done");
        wr_reg(AZS_CMD_ADDR, 32'h4);
        chk(AZS_CTRL_ADDR, 32'h1);
        chk(AZS_TYPE_QUERY_ADDR, AZS_ANS_PERIODIC);
        $display("test preset done");
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
endmodule // auto_zero_scheduler_bench

// *** azs_conv_model.sv ***
module azs_conv_model
    import azs_pkg::*;
#(
    parameter logic [23:0] S_VAL = 24'h001200,
    parameter logic [23:0] R_VAL = 24'h008000,
    parameter logic [23:0] Z_VAL = 24'h000100
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // converter link
    input wire logic conv_start,
    input wire logic [1:0] conv_phase,
    input wire logic slow,
    output logic conv_done,
    output logic [23:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_r;
    logic [3:0] cnt_r;
    logic [23:0] val;
    always_comb val = conv_phase == AZS_PH_SIGNAL ? S_VAL :
        conv_phase == AZS_PH_REFERENCE ? R_VAL : Z_VAL;
    // a new start drops any job in flight, as a real converter would
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= 24'h0;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (conv_start) begin
                busy_r <= 1'b1;
                cnt_r <= slow ? 4'h9 : 4'h1;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= val;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule // azs_conv_model

// *** azs_pkg.sv ***
package azs_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] AZS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] AZS_CMD_ADDR = 8'h04;
    localparam logic [7:0] AZS_STATUS_ADDR = 8'h08;
    localparam logic [7:0] AZS_TYPE_QUERY_ADDR = 8'h0c;
    localparam logic [7:0] AZS_ENABLE_QUERY_ADDR = 8'h10;

    // control register fields
    localparam int AZS_CTRL_ENABLE_BIT = 0;
    localparam int AZS_CTRL_TYPE_BIT = 1;
    localparam int AZS_CTRL_CONT_BIT = 2;

    // command register fields, write 1 to act
    localparam int AZS_CMD_ABORT_BIT = 0;
    localparam int AZS_CMD_INIT_BIT = 1;
    localparam int AZS_CMD_PRESET_BIT = 2;
    localparam int AZS_CMD_CLR_REFUSED_BIT = 3;

    // status register fields
    localparam int AZS_STAT_IDLE_BIT = 0;
    localparam int AZS_STAT_BUSY_BIT = 1;
    localparam int AZS_STAT_REFUSED_BIT = 2;
    localparam int AZS_STAT_ZERO_DUE_BIT = 3;

    // reset values
    localparam logic AZS_ENABLE_RST = 1'b1;
    localparam logic AZS_TYPE_RST = 1'b0;
    localparam logic AZS_CONT_RST = 1'b0;

    // zero type encodings
    localparam logic AZS_TYPE_PERIODIC = 1'b0;
    localparam logic AZS_TYPE_EVERY_READING = 1'b1;

    // query answers in ascii
    localparam logic [31:0] AZS_ANS_PERIODIC = 32'h4e4f524d;
    localparam logic [31:0] AZS_ANS_EVERY_READING = 32'h53594e43;
    localparam logic [7:0] AZS_ANS_ON = 8'h31;
    localparam logic [7:0] AZS_ANS_OFF = 8'h30;

    // converter phase codes
    localparam logic [1:0] AZS_PH_SIGNAL = 2'h0;
    localparam logic [1:0] AZS_PH_REFERENCE = 2'h1;
    localparam logic [1:0] AZS_PH_ZERO = 2'h2;

    // timing
    localparam longint AZS_CLK_HZ = 64'd50000000;
    localparam longint AZS_ZERO_PERIOD_MS = 64'd200;
    localparam longint AZS_ZERO_PERIOD_CYC = AZS_CLK_HZ / 64'd1000 * AZS_ZERO_PERIOD_MS;

    typedef enum logic [2:0] {
        AZS_ST_IDLE,
        AZS_ST_SIGNAL,
        AZS_ST_REFERENCE,
        AZS_ST_ZERO,
        AZS_ST_OUTPUT
    } azs_state_t;
endpackage

// *** azs_scheduler.sv ***
module azs_scheduler
    import azs_pkg::*;
#(
    parameter int DATA_W = 24,
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] ZERO_PERIOD_CYC = CNT_W'(AZS_ZERO_PERIOD_CYC)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // converter
    output logic conv_start,
    output logic [1:0] conv_phase,
    input wire logic conv_done,
    input wire logic [DATA_W-1:0] conv_data,
    // readings
    output logic reading_valid,
    output logic [DATA_W-1:0] reading_result,
    output logic [DATA_W-1:0] reading_span,
    output logic engine_idle
);
    typedef struct packed {
        azs_state_t state;
        logic busy;
        logic zero_enable_cmd;
        logic zero_type_select_cmd;
        logic continuous_trigger_ctl;
        logic run_once;
        logic zero_due;
        logic refused;
        logic [DATA_W-1:0] sig;
        logic [DATA_W-1:0] refv;
        logic [DATA_W-1:0] zero;
        logic [31:0] rdata;
        logic conv_start;
        logic [1:0] conv_phase;
        logic reading_valid;
        logic [DATA_W-1:0] result;
        logic [DATA_W-1:0] span;
        logic idle;
    } azs_main_state_t;

    azs_main_state_t s_r;
    azs_main_state_t s_nxt;

    azs_tick_if tk ();

    azs_tick_gen #(
        .CNT_W(CNT_W),
        .PERIOD_CYC(ZERO_PERIOD_CYC)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tk(tk)
    );

    // timer only runs for the periodic type with zero enabled; it restarts on any change of enable or type
    assign tk.run = s_r.zero_enable_cmd && (s_r.zero_type_select_cmd == AZS_TYPE_PERIODIC);

    always_comb begin
        logic zero_needed;
        zero_needed = 1'b0;
        s_nxt = s_r;
        s_nxt.conv_start = 1'b0;
        s_nxt.reading_valid = 1'b0;
        s_nxt.rdata = '0;

        // conversion sequence
        case (s_r.state)
            AZS_ST_IDLE: begin
                if (s_r.continuous_trigger_ctl || s_r.run_once) begin
                    s_nxt.state = AZS_ST_SIGNAL;
                    s_nxt.run_once = 1'b0;
                end
            end
            AZS_ST_SIGNAL: begin
                if (!s_r.busy) begin
                    s_nxt.conv_start = 1'b1;
                    s_nxt.conv_phase = AZS_PH_SIGNAL;
                    s_nxt.busy = 1'b1;
                end else if (conv_done) begin
                    s_nxt.sig = conv_data;
                    s_nxt.busy = 1'b0;
                    s_nxt.state = AZS_ST_REFERENCE;
                end
            end
            AZS_ST_REFERENCE: begin
                if (!s_r.busy) begin
                    s_nxt.conv_start = 1'b1;
                    s_nxt.conv_phase = AZS_PH_REFERENCE;
                    s_nxt.busy = 1'b1;
                end else if (conv_done) begin
                    s_nxt.refv = conv_data;
                    s_nxt.busy = 1'b0;
                    // periodic type only pays for zero when zero_due is set by the timer, reset, a preset or an enable change
                    zero_needed = s_r.zero_enable_cmd &&
                        (s_r.zero_type_select_cmd == AZS_TYPE_EVERY_READING || s_r.zero_due);
                    if (zero_needed) begin
                        s_nxt.state = AZS_ST_ZERO;
                    end else begin
                        s_nxt.state = AZS_ST_OUTPUT;
                    end
                end
            end
            AZS_ST_ZERO: begin
                if (!s_r.busy) begin
                    s_nxt.conv_start = 1'b1;
                    s_nxt.conv_phase = AZS_PH_ZERO;
                    s_nxt.busy = 1'b1;
                end else if (conv_done) begin
                    s_nxt.zero = conv_data;
                    s_nxt.zero_due = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.state = AZS_ST_OUTPUT;
                end
            end
            AZS_ST_OUTPUT: begin
                // with zero off the last stored zero is used, so accuracy drifts
                s_nxt.reading_valid = 1'b1;
                s_nxt.result = s_r.sig - s_r.zero;
                s_nxt.span = s_r.refv - s_r.zero;
                if (s_r.continuous_trigger_ctl) begin
                    s_nxt.state = AZS_ST_SIGNAL;
                end else begin
                    s_nxt.state = AZS_ST_IDLE;
                end
            end
            default: begin
                s_nxt.state = AZS_ST_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase

        // register reads, answered in the next cycle
        if (rd) begin
            case (addr)
                AZS_CTRL_ADDR: begin
                    s_nxt.rdata[AZS_CTRL_ENABLE_BIT] = s_r.zero_enable_cmd;
                    s_nxt.rdata[AZS_CTRL_TYPE_BIT] = s_r.zero_type_select_cmd;
                    s_nxt.rdata[AZS_CTRL_CONT_BIT] = s_r.continuous_trigger_ctl;
                end
                AZS_STATUS_ADDR: begin
                    s_nxt.rdata[AZS_STAT_IDLE_BIT] = s_r.state == AZS_ST_IDLE;
                    s_nxt.rdata[AZS_STAT_BUSY_BIT] = s_r.busy;
                    s_nxt.rdata[AZS_STAT_REFUSED_BIT] = s_r.refused;
                    s_nxt.rdata[AZS_STAT_ZERO_DUE_BIT] = s_r.zero_due;
                end
                AZS_TYPE_QUERY_ADDR: begin
                    if (s_r.zero_type_select_cmd == AZS_TYPE_EVERY_READING) begin
                        s_nxt.rdata = AZS_ANS_EVERY_READING;
                    end else begin
                        s_nxt.rdata = AZS_ANS_PERIODIC;
                    end
                end
                AZS_ENABLE_QUERY_ADDR: begin
                    s_nxt.rdata[7:0] = s_r.zero_enable_cmd ? AZS_ANS_ON : AZS_ANS_OFF;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end

        // register writes land at once, so a read in the next cycle sees them
        if (wr) begin
            case (addr)
                AZS_CTRL_ADDR: begin
                    s_nxt.zero_type_select_cmd = wdata[AZS_CTRL_TYPE_BIT];
                    s_nxt.continuous_trigger_ctl = wdata[AZS_CTRL_CONT_BIT];
                    if (wdata[AZS_CTRL_ENABLE_BIT] != s_r.zero_enable_cmd) begin
                        if (s_r.state == AZS_ST_IDLE) begin
                            s_nxt.zero_enable_cmd = wdata[AZS_CTRL_ENABLE_BIT];
                            s_nxt.zero_due = 1'b1;
                        end else begin
                            s_nxt.refused = 1'b1;
                        end
                    end
                end
                AZS_CMD_ADDR: begin
                    if (wdata[AZS_CMD_CLR_REFUSED_BIT]) begin
                        s_nxt.refused = 1'b0;
                    end
                    if (wdata[AZS_CMD_PRESET_BIT]) begin
                        s_nxt.zero_type_select_cmd = AZS_TYPE_RST;
                        s_nxt.zero_enable_cmd = AZS_ENABLE_RST;
                        s_nxt.zero_due = 1'b1;
                    end
                    if (wdata[AZS_CMD_ABORT_BIT]) begin
                        s_nxt.busy = 1'b0;
                        s_nxt.run_once = 1'b0;
                        // a start raised in the abort cycle would run the converter while idle
                        s_nxt.conv_start = 1'b0;
                        // abort under continuous triggering restarts the cycle
                        if (s_r.continuous_trigger_ctl) begin
                            s_nxt.state = AZS_ST_SIGNAL;
                        end else begin
                            s_nxt.state = AZS_ST_IDLE;
                        end
                    end else if (wdata[AZS_CMD_INIT_BIT] && s_r.state == AZS_ST_IDLE) begin
                        s_nxt.run_once = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // set wins over clear: a tick in the zero-capture cycle is kept
        if (tk.tick) begin
            s_nxt.zero_due = 1'b1;
        end
        // a refused change in the clearing cycle stays flagged
        if (wr && addr == AZS_CTRL_ADDR && s_r.state != AZS_ST_IDLE &&
                wdata[AZS_CTRL_ENABLE_BIT] != s_r.zero_enable_cmd) begin
            s_nxt.refused = 1'b1;
        end
        s_nxt.idle = s_nxt.state == AZS_ST_IDLE;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.state <= AZS_ST_IDLE;
            s_r.zero_enable_cmd <= AZS_ENABLE_RST;
            s_r.zero_type_select_cmd <= AZS_TYPE_RST;
            s_r.continuous_trigger_ctl <= AZS_CONT_RST;
            s_r.zero_due <= 1'b1;
            s_r.idle <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign conv_start = s_r.conv_start;
    assign conv_phase = s_r.conv_phase;
    assign reading_valid = s_r.reading_valid;
    assign reading_result = s_r.result;
    assign reading_span = s_r.span;
    assign engine_idle = s_r.idle;
endmodule // azs_scheduler

// *** azs_scheduler_monitor.sv ***
module azs_scheduler_monitor
    import azs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // converter and engine
    input wire logic conv_start,
    input wire logic [1:0] conv_phase,
    input wire logic conv_done,
    input wire logic reading_valid,
    input wire logic engine_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic en_r, typ_r, cont_r;
    wire ctl_wr = wr && addr == AZS_CTRL_ADDR;
    wire cmd_wr = wr && addr == AZS_CMD_ADDR;
    // shadow of the settings; enable only moves while the engine is idle or on a preset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_r <= AZS_ENABLE_RST;
            typ_r <= AZS_TYPE_RST;
            cont_r <= AZS_CONT_RST;
        end else if (ctl_wr) begin
            typ_r <= wdata[AZS_CTRL_TYPE_BIT];
            cont_r <= wdata[AZS_CTRL_CONT_BIT];
            if (engine_idle)
                en_r <= wdata[AZS_CTRL_ENABLE_BIT];
        end else if (cmd_wr && wdata[AZS_CMD_PRESET_BIT]) begin
            en_r <= 1'b1;
            typ_r <= AZS_TYPE_PERIODIC;
        end
    end
    rdata_quiet_a: assert property (rdata != 32'h0 |-> $past(rd))
        else $error("read data outside a read answer");
    type_answer_a: assert property ($past(rd) && $past(addr) == AZS_TYPE_QUERY_ADDR
        |-> rdata == ($past(typ_r) ? AZS_ANS_EVERY_READING : AZS_ANS_PERIODIC))
        else $error("type query answer wrong");
    enable_answer_a: assert property ($past(rd) && $past(addr) == AZS_ENABLE_QUERY_ADDR
        |-> rdata == {24'h0, $past(en_r) ? AZS_ANS_ON : AZS_ANS_OFF})
        else $error("enable query answer wrong");
    phase_order_a: assert property (conv_start && conv_phase != AZS_PH_SIGNAL
        |-> $past(conv_phase) == conv_phase - 2'h1)
        else $error("converter phase out of order");
    valid_after_done_a: assert property (reading_valid |-> $past(conv_done, 2))
        else $error("reading not two cycles after last done");
    idle_quiet_a: assert property (engine_idle && $past(engine_idle) |-> !conv_start)
        else $error("converter started while idle");
    abort_idle_a: assert property (cmd_wr && wdata[AZS_CMD_ABORT_BIT] && !cont_r
        |-> ##2 engine_idle)
        else $error("abort did not reach idle");
    init_start_a: assert property (cmd_wr && wdata[AZS_CMD_INIT_BIT]
        && !wdata[AZS_CMD_ABORT_BIT] && engine_idle
        |-> ##[1:3] conv_start && conv_phase == AZS_PH_SIGNAL)
        else $error("initiate did not start a signal phase");
    zero_skip_a: assert property (conv_start && !en_r |-> conv_phase != AZS_PH_ZERO)
        else $error("zero phase while disabled");
    zero_seen_c: cover property (conv_start && conv_phase == AZS_PH_ZERO);
    reading_c: cover property (reading_valid);
    refused_c: cover property (ctl_wr && !engine_idle);
endmodule // azs_scheduler_monitor

bind azs_scheduler azs_scheduler_monitor mon (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_start(conv_start),
    .conv_phase(conv_phase), .conv_done(conv_done), .reading_valid(reading_valid),
    .engine_idle(engine_idle));

// *** azs_tick_gen.sv ***
module azs_tick_gen
    import azs_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(AZS_ZERO_PERIOD_CYC)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // periodic zero timing
    azs_tick_if.gen tk
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } azs_tick_state_t;

    azs_tick_state_t s_r;
    azs_tick_state_t s_nxt;

    // counter restarts whenever run drops so the first interval is always whole
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!tk.run) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt == PERIOD_CYC - CNT_W'(1)) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tk.tick = s_r.tick;
endmodule // azs_tick_gen

// *** azs_tick_if.sv ***
interface azs_tick_if;
    logic run;
    logic tick;

    modport ctl (
        output run,
        input tick
    );

    modport gen (
        input run,
        output tick
    );
endinterface
